// [logic/mt_sync.sv]
// Contract
// - Load counter from first good read
// - Count singleturn cycles after startup
// - Repeat failed startup read
// - Mode zero: no read, internal 24-bit counter
// - Modes B..F read 4..18 multiturn bits
// - Modes 1..A carry singleturn bits too
// - Export external singleturn bits
// - Sync length sets bits and tolerance
// - Align read value with counted phase
// - Direction bit inverts received code
// - Error bit config selects evaluation
// - Frame length is data+sync+error bits
// - Add static offset before sync
// - Periodic verification when enabled
// - Verify command does one comparison
// - Mismatch sets counter error flag
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module mt_sync #(
	parameter int CHECK_CYCLES = mtp::CHECK_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic st_wrap_i,
	input wire logic st_up_i,
	input wire logic [3:0] st_phase_i,
	output logic ssi_clk_o,
	input wire logic ssi_data_i,
	output logic [23:0] mt_count_o,
	output logic [5:0] ext_st_o,
	output logic startup_done_o,
	output logic counter_error_o
);
	// Main domain state
	typedef struct packed {
		mtp::main_state_type st;
		logic [7:0] cfg_e; // Direction and error bit byte
		logic [7:0] cfg_o; // Offset byte
		logic [7:0] cfg_m; // Mode, sync length, check byte
		logic vreq; // Verify command pending
		logic [19:0] tmr; // Periodic check timer
		logic [23:0] cnt; // Multiturn counter
		logic [5:0] ext_st;
		logic done; // Startup finished
		logic cerr; // Sticky counter error
		logic req_tgl; // Frame request toward link
		logic [4:0] len; // Frame length, held per request
		logic ack_s1;
		logic ack_s2;
		logic ack_s3;
		logic [7:0] rdata;
	} main_type;

	// Link domain state
	typedef struct packed {
		mtp::link_state_type st;
		logic [1:0] ph; // Quarter of a bit period
		logic [4:0] bits; // Bits still to clock
		logic [7:0] gap; // Pause counter
		logic [22:0] sh; // Received word, last bit at 0
		logic clk; // Serial clock out
		logic ack_tgl; // Frame finished toward main
		logic rq_s1;
		logic rq_s2;
		logic rq_s3;
		logic d_s1;
		logic d_s2;
	} link_type;

	main_type m, n;
	link_type l, ln;
	logic [1:0] lrst_r; // Link reset release synchroniser
	logic lrst;

	// Decoded configuration
	logic [3:0] mode;
	logic [1:0] sbl;
	logic [1:0] ecfg;
	logic [3:0] ofs;
	logic inv;
	logic chk;
	logic [2:0] k; // Sync bit count
	logic eb; // Error bit present
	logic [4:0] db; // Data bits
	logic [2:0] stb; // Singleturn bits
	logic [4:0] flen;
	// Frame evaluation
	logic [27:0] msk;
	logic [27:0] dmsk;
	logic [27:0] w;
	logic [27:0] corr;
	logic [3:0] ph;
	logic [23:0] newd;
	logic bad;
	logic miss;
	logic ack_ev;
	logic trig;

	assign mode = m.cfg_m[mtp::MODE_LSB +: 4];
	assign sbl = m.cfg_m[mtp::SBL_LSB +: 2];
	assign chk = m.cfg_m[mtp::CHK_BIT];
	assign ecfg = m.cfg_e[mtp::ERR_LSB +: 2];
	assign inv = m.cfg_e[mtp::INV_BIT];
	assign ofs = m.cfg_o[mtp::OFS_LSB +: 4];
	assign k = {1'b0, sbl} + 3'h1;
	assign eb = (ecfg == mtp::ERR_LOW) || (ecfg == mtp::ERR_HIGH);
	assign db = mtp::data_bits(mode);
	assign stb = mtp::st_bits(mode);
	assign flen = db + {2'b00, k} + {4'h0, eb};
	assign ack_ev = m.ack_s2 ^ m.ack_s3;
	assign trig = (m.tmr == 20'(CHECK_CYCLES - 1));

	// Turn the received word into a multiturn value; word is
	// read only after the link has toggled its ack, so it is stable
	always_comb begin
		msk = (28'h1 << (db + {2'b00, k})) - 28'h1;
		dmsk = (28'h1 << db) - 28'h1;
		// Strip the error bit, keep data and sync bits
		w = ({5'h00, l.sh} >> eb) & msk;
		if (inv) begin
			w = ~w & msk;
		end
		// Offset acts on the data part only
		w = (w + ({24'h0, ofs} << k)) & msk;
		// Phase seen by us over the same sync bits
		ph = st_phase_i >> (3'h4 - k);
		// Half a step of bias rounds to the nearest turn
		corr = w - {24'h0, ph} + (28'h1 << (k - 3'h1));
		newd = 24'((corr >> k) & dmsk);
		// Active-low or active-high error bit is the last bit
		bad = ((ecfg == mtp::ERR_LOW) && !l.sh[0])
			|| ((ecfg == mtp::ERR_HIGH) && l.sh[0]);
		miss = (newd != (m.cnt & dmsk[23:0]));
	end

	// Main next state
	always_comb begin
		n = m;
		n.ack_s1 = l.ack_tgl;
		n.ack_s2 = m.ack_s1;
		n.ack_s3 = m.ack_s2;
		n.rdata = 8'h00;
		// Register reads, data stand one cycle later
		if (rd_i) begin
			case (addr_i)
				mtp::ADR_DIRERR: n.rdata = m.cfg_e;
				mtp::ADR_OFFSET: n.rdata = m.cfg_o;
				mtp::ADR_MODE: n.rdata = m.cfg_m;
				mtp::ADR_STAT: begin
					n.rdata[mtp::STB_ERR] = m.cerr;
					n.rdata[mtp::STB_DONE] = m.done;
					n.rdata[mtp::STB_BUSY] = (m.st == mtp::M_START_WAIT)
						|| (m.st == mtp::M_VER_WAIT);
				end
				mtp::ADR_CNT0: n.rdata = m.cnt[7:0];
				mtp::ADR_CNT1: n.rdata = m.cnt[15:8];
				mtp::ADR_CNT2: n.rdata = m.cnt[23:16];
				default: n.rdata = 8'h00; // Unmapped reads as zero
			endcase
		end
		// Register writes
		if (wr_i) begin
			case (addr_i)
				mtp::ADR_DIRERR: n.cfg_e = wdata_i & mtp::MSK_DIRERR;
				mtp::ADR_OFFSET: n.cfg_o = wdata_i & mtp::MSK_OFFSET;
				mtp::ADR_MODE: n.cfg_m = wdata_i & mtp::MSK_MODE;
				mtp::ADR_CMD: begin
					if (wdata_i[mtp::CMD_VER_BIT]) begin
						n.vreq = 1'b1;
					end
					// Host may rerun startup, e.g. after setting the mode
					if (wdata_i[mtp::CMD_START_BIT]) begin
						n.done = 1'b0;
					end
				end
				mtp::ADR_STAT: begin
					if (wdata_i[mtp::STB_ERR]) begin
						n.cerr = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Count turns once running; also while a check is in flight
		if (((m.st == mtp::M_RUN) || (m.st == mtp::M_VER_WAIT)) && st_wrap_i) begin
			n.cnt = st_up_i ? m.cnt + 24'h1 : m.cnt - 24'h1;
		end
		case (m.st)
			mtp::M_IDLE: begin
				if (mode == 4'h0) begin
					// No sensor: counter starts at zero
					n.cnt = 24'h0;
					n.done = 1'b1;
					n.st = mtp::M_RUN;
				end else begin
					n.req_tgl = ~m.req_tgl;
					n.len = flen;
					n.st = mtp::M_START_WAIT;
				end
			end
			mtp::M_START_WAIT: begin
				if (ack_ev) begin
					if (bad) begin
						n.st = mtp::M_IDLE;
					end else begin
						n.cnt = newd;
						n.done = 1'b1;
						n.st = mtp::M_RUN;
					end
				end
			end
			mtp::M_RUN: begin
				// Timer only runs with periodic checks on and a sensor
				if (chk && (mode != 4'h0)) begin
					n.tmr = m.tmr + 20'h1;
				end else begin
					n.tmr = 20'h0;
				end
				if ((mode != 4'h0) && (m.vreq || (chk && trig))) begin
					n.tmr = 20'h0;
					n.vreq = 1'b0;
					n.req_tgl = ~m.req_tgl;
					n.len = flen;
					n.st = mtp::M_VER_WAIT;
				end else if (!m.done) begin
					// Startup rerun: fetch a fresh start value, checks wait
					n.tmr = 20'h0;
					n.st = mtp::M_IDLE;
				end
			end
			mtp::M_VER_WAIT: begin
				// A failed read is no verdict; next check tries again
				if (ack_ev) begin
					if (!bad && miss) begin
						n.cerr = 1'b1;
					end
					n.st = mtp::M_RUN;
				end
			end
			default: n.st = mtp::M_IDLE;
		endcase
		// Singleturn bits taken from the counter's low end
		n.ext_st = 6'(n.cnt & ((24'h1 << stb) - 24'h1));
	end

	// Main registers
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			m <= '{st: mtp::M_IDLE, cfg_e: mtp::RST_DIRERR, cfg_o: mtp::RST_OFFSET,
				cfg_m: mtp::RST_MODE, default: '0};
		end else begin
			m <= n;
		end
	end

	// Link reset: asserts at once, releases on the link clock
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lrst_r <= 2'b11;
		end else begin
			lrst_r <= {lrst_r[0], 1'b0};
		end
	end
	assign lrst = lrst_r[1];

	// Link next state: four link cycles per bit so the two-stage
	// data synchroniser settles before each sample
	always_comb begin
		ln = l;
		ln.rq_s1 = m.req_tgl;
		ln.rq_s2 = l.rq_s1;
		ln.rq_s3 = l.rq_s2;
		ln.d_s1 = ssi_data_i;
		ln.d_s2 = l.d_s1;
		case (l.st)
			mtp::L_IDLE: begin
				ln.clk = 1'b1;
				if (l.rq_s2 ^ l.rq_s3) begin
					// Length is held by main until the ack
					ln.bits = m.len;
					ln.ph = 2'h0;
					ln.clk = 1'b0; // First falling edge latches
					ln.st = mtp::L_LATCH;
				end
			end
			mtp::L_LATCH: begin
				ln.ph = l.ph + 2'h1;
				if (l.ph == 2'h1) begin
					ln.ph = 2'h0;
					ln.clk = 1'b1;
					ln.st = mtp::L_SHIFT;
				end
			end
			mtp::L_SHIFT: begin
				ln.ph = l.ph + 2'h1;
				if (l.ph == 2'h1) begin
					ln.clk = 1'b0;
				end
				if (l.ph == 2'h3) begin
					ln.sh = {l.sh[21:0], l.d_s2};
					ln.bits = l.bits - 5'h01;
					ln.clk = 1'b1;
					if (l.bits == 5'h01) begin
						ln.gap = 8'h00;
						ln.st = mtp::L_PAUSE;
					end
				end
			end
			mtp::L_PAUSE: begin
				// Let the sensor's monoflop expire before the next frame
				ln.gap = l.gap + 8'h01;
				if (l.gap == 8'(mtp::PAUSE_CYC - 1)) begin
					ln.ack_tgl = ~l.ack_tgl;
					ln.st = mtp::L_IDLE;
				end
			end
			default: ln.st = mtp::L_IDLE;
		endcase
	end

	// Link registers
	always_ff @(posedge link_clk_i or posedge lrst) begin
		if (lrst) begin
			l <= '{st: mtp::L_IDLE, clk: 1'b1, default: '0};
		end else begin
			l <= ln;
		end
	end

	assign rdata_o = m.rdata;
	assign mt_count_o = m.cnt;
	assign ext_st_o = m.ext_st;
	assign startup_done_o = m.done;
	assign counter_error_o = m.cerr;
	assign ssi_clk_o = l.clk;

	// Checks
	AST_START_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_START_WAIT) && ack_ev && !bad
		|=> (m.cnt == $past(newd)) && m.done && (m.st == mtp::M_RUN))
		else $error("startup value not loaded");
	AST_COUNT: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_RUN) && st_wrap_i
		|=> m.cnt == (($past(st_up_i)) ? $past(m.cnt) + 24'h1 : $past(m.cnt) - 24'h1))
		else $error("counter did not follow turn");
	AST_RETRY: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_START_WAIT) && ack_ev && bad
		|=> !m.done ##1 (m.st == mtp::M_START_WAIT) && (m.req_tgl != $past(m.req_tgl, 2)))
		else $error("failed startup read not repeated");
	AST_MODE_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_IDLE) && (mode == 4'h0)
		|=> (m.cnt == 24'h0) && m.done && (m.req_tgl == $past(m.req_tgl)))
		else $error("mode zero started wrongly");
	AST_FRAME_LEN: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.req_tgl != $past(m.req_tgl)) |-> m.len == $past(flen))
		else $error("frame length wrong");
	AST_NO_PERIODIC: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_RUN) && m.done && !chk && !m.vreq |=> m.st == mtp::M_RUN)
		else $error("check without enable");
	AST_PERIODIC: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_RUN) && chk && trig && (mode != 4'h0)
		|=> (m.st == mtp::M_VER_WAIT) && (m.tmr == 20'h0))
		else $error("periodic check missed");
	AST_VERIFY_CMD: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_i && (addr_i == mtp::ADR_CMD) && wdata_i[mtp::CMD_VER_BIT]
		&& (m.st == mtp::M_RUN) && (mode != 4'h0) && !m.vreq && m.done
		|-> ##2 (m.st == mtp::M_VER_WAIT) && !m.vreq)
		else $error("verify command not served");
	AST_MISMATCH: assert property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_VER_WAIT) && ack_ev && !bad && miss |=> m.cerr ##1 (m.cerr
		|| $past(wr_i && (addr_i == mtp::ADR_STAT) && wdata_i[mtp::STB_ERR])))
		else $error("mismatch not flagged");
	AST_SCLK_IDLE: assert property (@(posedge link_clk_i) disable iff (lrst)
		(l.st == mtp::L_IDLE) && !(l.rq_s2 ^ l.rq_s3) |=> ssi_clk_o)
		else $error("serial clock low while idle");
	COV_STARTUP: cover property (@(posedge clock_i) disable iff (rst_i) $rose(m.done));
	COV_RETRY: cover property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_START_WAIT) && ack_ev && bad);
	COV_MISMATCH: cover property (@(posedge clock_i) disable iff (rst_i) $rose(m.cerr));
	COV_VERIFY: cover property (@(posedge clock_i) disable iff (rst_i)
		(m.st == mtp::M_VER_WAIT) && ack_ev && !miss);
endmodule
`default_nettype wire

// [logic/mtp.sv]
`default_nettype none
package mtp;
	// Register byte offsets
	localparam logic [7:0] ADR_DIRERR = 8'h0e;
	localparam logic [7:0] ADR_OFFSET = 8'h0f;
	localparam logic [7:0] ADR_MODE = 8'h10;
	localparam logic [7:0] ADR_CMD = 8'h11;
	localparam logic [7:0] ADR_STAT = 8'h12;
	localparam logic [7:0] ADR_CNT0 = 8'h13;
	localparam logic [7:0] ADR_CNT1 = 8'h14;
	localparam logic [7:0] ADR_CNT2 = 8'h15;
	// Field positions
	localparam int INV_BIT = 5;
	localparam int ERR_LSB = 6;
	localparam int OFS_LSB = 4;
	localparam int MODE_LSB = 0;
	localparam int SBL_LSB = 4;
	localparam int CHK_BIT = 6;
	localparam int CMD_VER_BIT = 0;
	localparam int CMD_START_BIT = 1;
	localparam int STB_ERR = 0;
	localparam int STB_DONE = 1;
	localparam int STB_BUSY = 2;
	// Writable bits of each configuration byte
	localparam logic [7:0] MSK_DIRERR = 8'he0;
	localparam logic [7:0] MSK_OFFSET = 8'hf0;
	localparam logic [7:0] MSK_MODE = 8'h7f;
	// Reset values
	localparam logic [7:0] RST_DIRERR = 8'h00;
	localparam logic [7:0] RST_OFFSET = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	// Error bit codes
	localparam logic [1:0] ERR_LOW = 2'h1;
	localparam logic [1:0] ERR_HIGH = 2'h3;
	// Timing
	localparam int CLK_KHZ = 10000;
	localparam int LINK_KHZ = 8000;
	localparam int PAUSE_NS = 20000;
	localparam int PAUSE_CYC = (PAUSE_NS * LINK_KHZ + 999999) / 1000000;
	localparam int CHECK_MS = 10;
	localparam int CHECK_CYC = CHECK_MS * CLK_KHZ;
	// Widths
	localparam int CNT_W = 24;
	localparam int RX_W = 23;

	typedef enum logic [1:0] {M_IDLE, M_START_WAIT, M_RUN, M_VER_WAIT} main_state_type;
	typedef enum logic [1:0] {L_IDLE, L_LATCH, L_SHIFT, L_PAUSE} link_state_type;

	// Data bits in a frame for each mode
	function automatic logic [4:0] data_bits(input logic [3:0] md);
		case (md)
			4'h0: return 5'h00;
			4'h7, 4'h8, 4'h9, 4'ha: return {1'b0, md} + 5'h08;
			4'hb: return 5'h04;
			4'hc: return 5'h08;
			4'hd: return 5'h0c;
			4'he: return 5'h10;
			4'hf: return 5'h12;
			default: return {1'b0, md};
		endcase
	endfunction

	// Low data bits that belong to the singleturn position
	function automatic logic [2:0] st_bits(input logic [3:0] md);
		case (md)
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: return md[2:0];
			4'h7, 4'h8, 4'h9, 4'ha: return 3'(md - 4'h4);
			default: return 3'h0;
		endcase
	endfunction
endpackage
`default_nettype wire

// [tb/ssi_sensor.sv]
`timescale 1ns/100ps
`default_nettype none
// Behavioural serial sensor: MSB first, one bit per clock rise
module ssi_sensor (
	input wire logic link_clk_i,
	input wire logic ssi_clk_i,
	input wire logic [31:0] word_i,
	input wire logic [5:0] len_i,
	output logic data_o,
	output int bits_o,
	output int frames_o
);
	logic [31:0] shift_r; // Word latched at frame start
	logic busy; // Frame in progress
	int falls; // Falling clock edges seen in this frame
	int left; // Bits still to send
	int idle; // Link cycles with the clock high

	initial begin
		data_o = 1'b1;
		busy = 1'b0;
		bits_o = 0;
		frames_o = 0;
		idle = 0;
	end

	// First fall latches the word; each later fall falls inside one bit period and counts that bit
	always @(negedge ssi_clk_i) begin
		if (!busy) begin
			busy = 1'b1;
			falls = 0;
			shift_r = word_i;
			left = int'(len_i);
		end
		falls = falls + 1;
	end

	// Data changes right after a rise, well before the sampling point
	always @(posedge ssi_clk_i) begin
		if (busy && left > 0) begin
			data_o = shift_r[left-1];
			left = left - 1;
		end else begin
			// Released line: show the inverse so a stale value never passes
			data_o = ~data_o;
		end
	end

	// A long high clock closes the frame; bits are falls minus the latch fall
	always @(posedge link_clk_i) begin
		if (busy && ssi_clk_i) begin
			idle = idle + 1;
		end else begin
			idle = 0;
		end
		if (busy && idle >= 8) begin
			busy = 1'b0;
			bits_o = falls - 1;
			frames_o = frames_o + 1;
		end
	end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clock_i; // Main clock, 100 ns
	logic link_clk_i; // Link clock, 125 ns, own phase
	logic rst_i;
	logic [7:0] addr_i;
	logic [7:0] wdata_i;
	logic wr_i;
	logic rd_i;
	logic [7:0] rdata_o;
	logic st_wrap_i;
	logic st_up_i;
	logic [3:0] st_phase_i;
	logic ssi_clk_o;
	logic ssi_data_i;
	logic [23:0] mt_count_o;
	logic [5:0] ext_st_o;
	logic startup_done_o;
	logic counter_error_o;
	logic [31:0] word; // Frame the sensor sends next
	logic [5:0] len; // Its length in bits
	int bits; // Bits clocked in the last frame
	int frames; // Frames completed
	int error_cnt = 0;
	int total_checks = 0;

	// Short check interval keeps the periodic scenario brief
	mt_sync #(.CHECK_CYCLES(2000)) DUT (.clock_i(clock_i), .rst_i(rst_i),
		.link_clk_i(link_clk_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .st_wrap_i(st_wrap_i), .st_up_i(st_up_i),
		.st_phase_i(st_phase_i), .ssi_clk_o(ssi_clk_o), .ssi_data_i(ssi_data_i),
		.mt_count_o(mt_count_o), .ext_st_o(ext_st_o), .startup_done_o(startup_done_o),
		.counter_error_o(counter_error_o));
	ssi_sensor sensor (.link_clk_i(link_clk_i), .ssi_clk_i(ssi_clk_o), .word_i(word),
		.len_i(len), .data_o(ssi_data_i), .bits_o(bits), .frames_o(frames));

	// Clocks
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#17;
		forever #62.5 link_clk_i = ~link_clk_i;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic timeout();
		error_cnt++;
		wrap_up();
	endtask
	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// One completed singleturn cycle
	task automatic turn(input logic up);
		@(posedge clock_i);
		st_wrap_i <= 1'b1;
		st_up_i <= up;
		@(posedge clock_i);
		st_wrap_i <= 1'b0;
	endtask
	// Commanded verification against one sensor frame
	task automatic ver(input logic [31:0] w, input int n, input logic e);
		int f0;
		logic [7:0] s;
		f0 = frames;
		word = w;
		len = 6'(n);
		wr(mtp::ADR_STAT, 8'h01);
		wr(mtp::ADR_CMD, 8'h01);
		for (int i = 0; i < 4000 && frames == f0; i++) @(posedge clock_i);
		if (frames == f0) timeout();
		s = 8'h04;
		for (int i = 0; i < 400 && s[mtp::STB_BUSY]; i++) rd(mtp::ADR_STAT, s);
		if (s[mtp::STB_BUSY]) timeout();
		repeat (2) @(posedge clock_i);
		chk(32'(counter_error_o), 32'(e));
		chk(32'(bits), 32'(n));
	endtask

	task automatic t_reset();
		logic [7:0] v;
		chk(32'(mt_count_o), 32'h0);
		chk(32'(startup_done_o), 32'h1);
		chk(32'(counter_error_o), 32'h0);
		chk(32'(ssi_clk_o), 32'h1);
		rd(mtp::ADR_DIRERR, v);
		chk(32'(v), 32'(mtp::RST_DIRERR));
		rd(mtp::ADR_OFFSET, v);
		chk(32'(v), 32'(mtp::RST_OFFSET));
		rd(mtp::ADR_MODE, v);
		chk(32'(v), 32'(mtp::RST_MODE));
		rd(mtp::ADR_STAT, v);
		chk(32'(v), 32'h02);
		rd(8'h40, v);
		chk(32'(v), 32'h0);
	endtask
	// Writable bits only; counter bytes are read-only
	task automatic t_regs();
		logic [7:0] ad[3] = '{mtp::ADR_DIRERR, mtp::ADR_OFFSET, mtp::ADR_MODE};
		logic [7:0] mk[3] = '{mtp::MSK_DIRERR, mtp::MSK_OFFSET, mtp::MSK_MODE};
		logic [7:0] v;
		for (int i = 0; i < 3; i++) begin
			wr(ad[i], 8'hff);
			rd(ad[i], v);
			chk(32'(v), 32'(mk[i]));
			wr(ad[i], 8'h00);
		end
		wr(mtp::ADR_CNT0, 8'hff);
		rd(mtp::ADR_CNT0, v);
		chk(32'(v), 32'h0);
	endtask
	// Down through zero, then up to five
	task automatic t_count();
		logic [7:0] v;
		turn(1'b0);
		repeat (2) @(posedge clock_i);
		chk(32'(mt_count_o), 32'h00ffffff);
		repeat (6) turn(1'b1);
		repeat (2) @(posedge clock_i);
		chk(32'(mt_count_o), 32'h5);
		rd(mtp::ADR_CNT0, v);
		chk(32'(v), 32'h05);
		rd(mtp::ADR_CNT2, v);
		chk(32'(v), 32'h00);
	endtask
	// Every mode: exported singleturn bits and frame length
	task automatic t_modes();
		byte dbt[16] = '{0, 1, 2, 3, 4, 5, 6, 15, 16, 17, 18, 4, 8, 12, 16, 18};
		byte stt[16] = '{0, 1, 2, 3, 4, 5, 6, 3, 4, 5, 6, 0, 0, 0, 0, 0};
		int d;
		for (int m = 1; m < 16; m++) begin
			wr(mtp::ADR_MODE, 8'(m));
			repeat (2) @(posedge clock_i);
			chk(32'(ext_st_o), 32'(5 & ((1 << stt[m]) - 1)));
			d = 5 & ((1 << dbt[m]) - 1);
			ver(32'(d) << 1, dbt[m] + 1, 1'b0);
		end
		wr(mtp::ADR_MODE, 8'h00);
		repeat (2) @(posedge clock_i);
		chk(32'(ext_st_o), 32'h0);
	endtask
	// Four data bits against a count of five
	task automatic t_sync();
		logic [7:0] v;
		wr(mtp::ADR_MODE, 8'h0b);
		ver(32'h0c, 5, 1'b1);
		rd(mtp::ADR_STAT, v);
		chk(32'(v[mtp::STB_ERR]), 32'h1);
		wr(mtp::ADR_STAT, 8'h01);
		rd(mtp::ADR_STAT, v);
		chk(32'(v[mtp::STB_ERR]), 32'h0);
		wr(mtp::ADR_OFFSET, 8'h20);
		ver(32'h06, 5, 1'b0);
		wr(mtp::ADR_OFFSET, 8'h00);
		wr(mtp::ADR_DIRERR, 8'h20);
		ver(32'h15, 5, 1'b0);
		wr(mtp::ADR_DIRERR, 8'hc0);
		ver(32'h14, 6, 1'b0);
		ver(32'h25, 6, 1'b0);
		wr(mtp::ADR_DIRERR, 8'h40);
		ver(32'h24, 6, 1'b0);
		ver(32'h25, 6, 1'b1);
		wr(mtp::ADR_DIRERR, 8'h80);
		ver(32'h0a, 5, 1'b0);
		wr(mtp::ADR_DIRERR, 8'h00);
		// Phase off by one sync step, then by five, still lands on the counted turn
		st_phase_i <= 4'h4;
		wr(mtp::ADR_MODE, 8'h1b);
		ver(32'h16, 6, 1'b0);
		wr(mtp::ADR_MODE, 8'h3b);
		ver(32'h59, 8, 1'b0);
		st_phase_i <= 4'h0;
	endtask
	// No frames while checking is off, a flagged mismatch once it is on
	task automatic t_periodic();
		int f0;
		word = 32'h0e;
		len = 6'd5;
		wr(mtp::ADR_MODE, 8'h0b);
		wr(mtp::ADR_STAT, 8'h01);
		f0 = frames;
		repeat (2500) @(posedge clock_i);
		chk(32'(frames - f0), 32'h0);
		chk(32'(counter_error_o), 32'h0);
		wr(mtp::ADR_MODE, 8'h4b);
		for (int i = 0; i < 3000 && counter_error_o !== 1'b1; i++) @(posedge clock_i);
		if (counter_error_o !== 1'b1) timeout();
		chk(32'(counter_error_o), 32'h1);
		wr(mtp::ADR_MODE, 8'h0b);
	endtask
	// Startup rerun: a frame with its active-low error bit low is read again
	task automatic t_startup();
		int f0;
		wr(mtp::ADR_MODE, 8'h0d);
		wr(mtp::ADR_DIRERR, 8'h40);
		word = 32'h48c;
		len = 6'd14;
		f0 = frames;
		wr(mtp::ADR_CMD, 8'h02);
		for (int i = 0; i < 4000 && frames == f0; i++) @(posedge clock_i);
		if (frames == f0) timeout();
		chk(32'(startup_done_o), 32'h0);
		// Good frame: data 0x123, sync 0, error bit high
		word = 32'h48d;
		for (int i = 0; i < 4000 && startup_done_o !== 1'b1; i++) @(posedge clock_i);
		if (startup_done_o !== 1'b1) timeout();
		chk(32'(frames - f0), 32'h2);
		chk(32'(bits), 32'd14);
		chk(32'(mt_count_o), 32'h123);
		wr(mtp::ADR_DIRERR, 8'h00);
	endtask

	// Main sequence
	initial begin
		rst_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		st_wrap_i = 1'b0;
		st_up_i = 1'b1;
		st_phase_i = 4'h0;
		word = 32'h0;
		len = 6'd1;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		t_reset();
		t_regs();
		t_count();
		t_modes();
		t_sync();
		t_periodic();
		t_startup();
		wrap_up();
	end
endmodule
`default_nettype wire
